// *** ucrm_pkg.sv ***
// Purpose: Shared constants and helpers for the serial channel register map
// Assumes: Eight-bit registers, three-bit offset, one channel per instance
// Notes: Bank selection and extended-field gating helpers live here
package ucrm_pkg;

	// Register offsets
	localparam logic [2:0] OFS_HOLD = 3'h0;
	localparam logic [2:0] OFS_INT_EN = 3'h1;
	localparam logic [2:0] OFS_STAT_FIFO = 3'h2;
	localparam logic [2:0] OFS_LINE_CTL = 3'h3;
	localparam logic [2:0] OFS_MODEM_CTL = 3'h4;
	localparam logic [2:0] OFS_LINE_STAT = 3'h5;
	localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
	localparam logic [2:0] OFS_SCRATCH = 3'h7;

	// Field positions
	localparam int DIV_ACCESS_BIT = 7;
	localparam int ENH_UNLOCK_BIT = 4;
	localparam int FIFO_EN_BIT = 0;
	localparam int RX_RST_BIT = 1;
	localparam int TX_RST_BIT = 2;

	// Extended field masks
	localparam logic [7:0] INT_EN_EXT_MASK = 8'hF0;
	localparam logic [7:0] STAT_EXT_MASK = 8'h30;
	localparam logic [7:0] FIFO_EXT_MASK = 8'h30;
	localparam logic [7:0] MODEM_EXT_MASK = 8'hE0;
	localparam logic [7:0] FRAC_USED_MASK = 8'h3F;
	localparam logic [7:0] FIFO_PULSE_MASK = 8'h06;

	// Special values
	localparam logic [7:0] ENHANCED_KEY = 8'hBF;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] IDLE_BYTE = 8'h00;

	// Synchroniser depth
	localparam int SYNC_STAGES = 2;

	typedef enum {BANK_NORMAL, BANK_DIVISOR, BANK_ENHANCED} ucrm_bank_t;

	function automatic ucrm_bank_t ucrm_bank_of(input logic [7:0] line_ctl);
		if (line_ctl == ENHANCED_KEY) begin
			return BANK_ENHANCED;
		end else if (line_ctl[DIV_ACCESS_BIT]) begin
			return BANK_DIVISOR;
		end
		return BANK_NORMAL;
	endfunction : ucrm_bank_of

	// Clears the extended bits of a byte when they are locked
	function automatic logic [7:0] ucrm_gate(input logic [7:0] value, input logic [7:0] mask, input logic unlocked);
		return unlocked ? value : (value & ~mask);
	endfunction : ucrm_gate

endpackage : ucrm_pkg

// *** ucrm_sync.sv ***
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs are levels from outside the sys_clk domain
// Notes: First stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module ucrm_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] next_meta;
	logic [WIDTH-1:0] next_sync_out;

	always_comb begin
		next_meta = resetn ? async_in : INIT;
		next_sync_out = resetn ? meta : INIT;
	end

	always_ff @(posedge sys_clk) begin
		meta <= next_meta;
		sync_out <= next_sync_out;
	end
endmodule : ucrm_sync
`default_nettype wire

// *** ucrm_bus_port.sv ***
// Purpose: Turns the asynchronous host strobes into one-cycle access pulses
// Assumes: Address and data settle before the strobe ends
// Notes: Writes take effect at the trailing edge of the write strobe
`timescale 1ns/100ps
`default_nettype none
module ucrm_bus_port (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic chan_sel_n,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [2:0] addr,
	input wire logic [7:0] data_in,
	output logic rd_start,
	output logic rd_active,
	output logic wr_pulse,
	output logic [2:0] acc_addr,
	output logic [7:0] acc_data
);
	import ucrm_pkg::*;

	logic [13:0] pins_s;
	logic sel_q;
	logic iow_q;
	logic [2:0] addr_q;
	logic [7:0] data_q;
	logic next_rd_start;
	logic next_rd_active;
	logic next_wr_pulse;
	logic [2:0] next_acc_addr;
	logic [7:0] next_acc_data;

	// Strobes idle high so reset does not fake an access
	ucrm_sync #(.WIDTH(14), .INIT(14'h0007)) u_sync (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.async_in({addr, data_in, iow_n, ior_n, chan_sel_n}),
		.sync_out(pins_s)
	);

	always_comb begin
		next_rd_active = ~pins_s[0] & ~pins_s[1];
		next_rd_start = next_rd_active & ~rd_active;
		// Trailing edge: address and data have had the whole strobe to settle
		next_wr_pulse = sel_q & ~iow_q & pins_s[2];
		next_acc_addr = next_wr_pulse ? addr_q : pins_s[13:11];
		next_acc_data = data_q;
		if (!resetn) begin
			next_rd_active = 1'b0;
			next_rd_start = 1'b0;
			next_wr_pulse = 1'b0;
			next_acc_addr = OFS_HOLD;
			next_acc_data = RESET_BYTE;
		end
	end

	always_ff @(posedge sys_clk) begin
		sel_q <= resetn & ~pins_s[0];
		iow_q <= resetn ? pins_s[2] : 1'b1;
		addr_q <= pins_s[13:11];
		data_q <= pins_s[10:3];
		rd_start <= next_rd_start;
		rd_active <= next_rd_active;
		wr_pulse <= next_wr_pulse;
		acc_addr <= next_acc_addr;
		acc_data <= next_acc_data;
	end
endmodule : ucrm_bus_port
`default_nettype wire

// *** ucrm_regs.sv ***
// Purpose: Register file and bank decode for one serial channel
// Assumes: Status inputs come from channel logic on sys_clk
// Notes: All outputs are registered; pulses last one cycle
`timescale 1ns/100ps
`default_nettype none
module ucrm_regs (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic chan_sel_n,
	input wire logic [2:0] addr,
	input wire logic ior_n,
	input wire logic iow_n,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	input wire logic [7:0] rx_holding,
	input wire logic [3:0] int_source,
	input wire logic pause_int_flag,
	input wire logic handshake_int_flag,
	input wire logic [7:0] line_status,
	input wire logic [3:0] modem_delta,
	input wire logic [3:0] modem_state,
	output logic rx_read_pulse,
	output logic tx_load_pulse,
	output logic [7:0] tx_holding,
	output logic line_status_read_pulse,
	output logic modem_status_read_pulse,
	output logic rx_fifo_reset,
	output logic tx_fifo_reset,
	output logic [7:0] interrupt_enable,
	output logic [7:0] fifo_control,
	output logic [7:0] line_control,
	output logic [7:0] modem_control,
	output logic [7:0] scratch_pad,
	output logic [7:0] divisor_low,
	output logic [7:0] divisor_high,
	output logic [7:0] divisor_fraction,
	output logic [7:0] enhanced_function,
	output logic [7:0] resume_char_1,
	output logic [7:0] resume_char_2,
	output logic [7:0] pause_char_1,
	output logic [7:0] pause_char_2
);
	import ucrm_pkg::*;

	logic rd_start;
	logic rd_active;
	logic wr_pulse;
	logic [2:0] acc_addr;
	logic [7:0] acc_data;
	ucrm_bank_t bank;
	logic unlocked;
	logic [7:0] status_value;
	logic [7:0] read_value;

	logic [7:0] next_data_out;
	logic next_data_oe;
	logic next_rx_read_pulse;
	logic next_tx_load_pulse;
	logic [7:0] next_tx_holding;
	logic next_lstat_read;
	logic next_mstat_read;
	logic next_rx_fifo_reset;
	logic next_tx_fifo_reset;
	logic [7:0] next_int_en;
	logic [7:0] next_fifo_ctl;
	logic [7:0] next_line_ctl;
	logic [7:0] next_modem_ctl;
	logic [7:0] next_scratch;
	logic [7:0] next_div_low;
	logic [7:0] next_div_high;
	logic [7:0] next_div_frac;
	logic [7:0] next_enh_func;
	logic [7:0] next_resume_1;
	logic [7:0] next_resume_2;
	logic [7:0] next_pause_1;
	logic [7:0] next_pause_2;
	logic next_unlocked;

	// Only this channel's select reaches the access logic
	ucrm_bus_port u_port (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.chan_sel_n(chan_sel_n),
		.ior_n(ior_n),
		.iow_n(iow_n),
		.addr(addr),
		.data_in(data_in),
		.rd_start(rd_start),
		.rd_active(rd_active),
		.wr_pulse(wr_pulse),
		.acc_addr(acc_addr),
		.acc_data(acc_data)
	);

	always_comb begin
		bank = ucrm_bank_of(line_control);
		unlocked = enhanced_function[ENH_UNLOCK_BIT];
		status_value = {{2{fifo_control[FIFO_EN_BIT]}}, handshake_int_flag, pause_int_flag, int_source};
		status_value = ucrm_gate(status_value, STAT_EXT_MASK, unlocked);
	end

	// Read decode
	always_comb begin
		read_value = IDLE_BYTE;
		unique case (acc_addr)
			OFS_HOLD: begin
				if (bank == BANK_NORMAL) begin
					read_value = rx_holding;
				end else begin
					read_value = divisor_low;
				end
			end
			OFS_INT_EN: begin
				if (bank == BANK_NORMAL) begin
					read_value = interrupt_enable;
				end else begin
					read_value = divisor_high;
				end
			end
			OFS_STAT_FIFO: begin
				if (bank == BANK_NORMAL) begin
					read_value = status_value;
				end else if (bank == BANK_ENHANCED) begin
					read_value = enhanced_function;
				end else if (unlocked) begin
					read_value = divisor_fraction;
				end
			end
			OFS_LINE_CTL: read_value = line_control;
			OFS_MODEM_CTL: read_value = (bank == BANK_ENHANCED) ? resume_char_1 : modem_control;
			OFS_LINE_STAT: begin
				if (bank == BANK_ENHANCED) begin
					read_value = resume_char_2;
				end else if (bank == BANK_NORMAL) begin
					read_value = line_status;
				end
			end
			OFS_MODEM_STAT: begin
				if (bank == BANK_ENHANCED) begin
					read_value = pause_char_1;
				end else if (bank == BANK_NORMAL) begin
					read_value = {modem_state, modem_delta};
				end
			end
			OFS_SCRATCH: read_value = (bank == BANK_ENHANCED) ? pause_char_2 : scratch_pad;
		endcase
	end

	// Bus answer and read side effects
	always_comb begin
		next_data_oe = rd_active;
		next_data_out = rd_active ? read_value : data_out;
		next_rx_read_pulse = rd_start & (bank == BANK_NORMAL) & (acc_addr == OFS_HOLD);
		next_lstat_read = rd_start & (bank == BANK_NORMAL) & (acc_addr == OFS_LINE_STAT);
		next_mstat_read = rd_start & (bank == BANK_NORMAL) & (acc_addr == OFS_MODEM_STAT);
		if (!resetn) begin
			next_data_oe = 1'b0;
			next_data_out = RESET_BYTE;
			next_rx_read_pulse = 1'b0;
			next_lstat_read = 1'b0;
			next_mstat_read = 1'b0;
		end
	end

	// Write decode
	always_comb begin
		next_tx_load_pulse = 1'b0;
		next_tx_holding = tx_holding;
		next_rx_fifo_reset = 1'b0;
		next_tx_fifo_reset = 1'b0;
		next_int_en = interrupt_enable;
		next_fifo_ctl = fifo_control;
		next_line_ctl = line_control;
		next_modem_ctl = modem_control;
		next_scratch = scratch_pad;
		next_div_low = divisor_low;
		next_div_high = divisor_high;
		next_div_frac = divisor_fraction;
		next_enh_func = enhanced_function;
		next_resume_1 = resume_char_1;
		next_resume_2 = resume_char_2;
		next_pause_1 = pause_char_1;
		next_pause_2 = pause_char_2;
		if (wr_pulse) begin
			unique case (acc_addr)
				OFS_HOLD: begin
					if (bank == BANK_NORMAL) begin
						next_tx_holding = acc_data;
						next_tx_load_pulse = 1'b1;
					end else begin
						next_div_low = acc_data;
					end
				end
				OFS_INT_EN: begin
					if (bank == BANK_NORMAL) begin
						next_int_en = ucrm_gate(acc_data, INT_EN_EXT_MASK, unlocked);
					end else begin
						next_div_high = acc_data;
					end
				end
				OFS_STAT_FIFO: begin
					if (bank == BANK_NORMAL) begin
						// Reset bits are actions, not state
						next_fifo_ctl = ucrm_gate(acc_data & ~FIFO_PULSE_MASK, FIFO_EXT_MASK, unlocked);
						next_rx_fifo_reset = acc_data[RX_RST_BIT];
						next_tx_fifo_reset = acc_data[TX_RST_BIT];
					end else if (bank == BANK_ENHANCED) begin
						next_enh_func = acc_data;
					end else if (unlocked) begin
						next_div_frac = acc_data & FRAC_USED_MASK;
					end
				end
				OFS_LINE_CTL: next_line_ctl = acc_data;
				OFS_MODEM_CTL: begin
					if (bank == BANK_ENHANCED) begin
						next_resume_1 = acc_data;
					end else begin
						next_modem_ctl = ucrm_gate(acc_data, MODEM_EXT_MASK, unlocked);
					end
				end
				OFS_LINE_STAT: begin
					// Line status is owned by the receiver; host writes here only load resume_char_2 in the enhanced bank
					if (bank == BANK_ENHANCED) begin
						next_resume_2 = acc_data;
					end
				end
				OFS_MODEM_STAT: begin
					if (bank == BANK_ENHANCED) begin
						next_pause_1 = acc_data;
					end
				end
				OFS_SCRATCH: begin
					if (bank == BANK_ENHANCED) begin
						next_pause_2 = acc_data;
					end else begin
						next_scratch = acc_data;
					end
				end
			endcase
		end
		// Locking again drops any extended setting so it cannot linger unseen
		next_unlocked = next_enh_func[ENH_UNLOCK_BIT];
		next_int_en = ucrm_gate(next_int_en, INT_EN_EXT_MASK, next_unlocked);
		next_fifo_ctl = ucrm_gate(next_fifo_ctl, FIFO_EXT_MASK, next_unlocked);
		next_modem_ctl = ucrm_gate(next_modem_ctl, MODEM_EXT_MASK, next_unlocked);
		next_div_frac = next_unlocked ? next_div_frac : RESET_BYTE;
		if (!resetn) begin
			next_tx_load_pulse = 1'b0;
			next_tx_holding = RESET_BYTE;
			next_rx_fifo_reset = 1'b0;
			next_tx_fifo_reset = 1'b0;
			next_int_en = RESET_BYTE;
			next_fifo_ctl = RESET_BYTE;
			next_line_ctl = RESET_BYTE;
			next_modem_ctl = RESET_BYTE;
			next_scratch = RESET_BYTE;
			next_div_low = RESET_BYTE;
			next_div_high = RESET_BYTE;
			next_div_frac = RESET_BYTE;
			next_enh_func = RESET_BYTE;
			next_resume_1 = RESET_BYTE;
			next_resume_2 = RESET_BYTE;
			next_pause_1 = RESET_BYTE;
			next_pause_2 = RESET_BYTE;
		end
	end

	always_ff @(posedge sys_clk) begin
		data_out <= next_data_out;
		data_oe <= next_data_oe;
		rx_read_pulse <= next_rx_read_pulse;
		line_status_read_pulse <= next_lstat_read;
		modem_status_read_pulse <= next_mstat_read;
	end

	always_ff @(posedge sys_clk) begin
		tx_load_pulse <= next_tx_load_pulse;
		tx_holding <= next_tx_holding;
		rx_fifo_reset <= next_rx_fifo_reset;
		tx_fifo_reset <= next_tx_fifo_reset;
		interrupt_enable <= next_int_en;
		fifo_control <= next_fifo_ctl;
		line_control <= next_line_ctl;
		modem_control <= next_modem_ctl;
		scratch_pad <= next_scratch;
		divisor_low <= next_div_low;
		divisor_high <= next_div_high;
		divisor_fraction <= next_div_frac;
		enhanced_function <= next_enh_func;
		resume_char_1 <= next_resume_1;
		resume_char_2 <= next_resume_2;
		pause_char_1 <= next_pause_1;
		pause_char_2 <= next_pause_2;
	end
endmodule : ucrm_regs
`default_nettype wire

// *** ucrm_regs_asserts.sv ***
// Purpose: Port-level checks for one channel register map
// Assumes: Host strobes pass two sync flops before use
// Notes: Release window ends exactly at the four-cycle strobe-to-output latency, with no slack
`timescale 1ns/100ps
`default_nettype none
module ucrm_regs_asserts (
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic chan_sel_n,
	input wire logic ior_n,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic [7:0] rx_holding,
	input wire logic [7:0] line_status,
	input wire logic [3:0] modem_delta,
	input wire logic [3:0] modem_state,
	input wire logic rx_read_pulse,
	input wire logic tx_load_pulse,
	input wire logic line_status_read_pulse,
	input wire logic modem_status_read_pulse,
	input wire logic rx_fifo_reset,
	input wire logic tx_fifo_reset,
	input wire logic [7:0] interrupt_enable,
	input wire logic [7:0] fifo_control,
	input wire logic [7:0] line_control,
	input wire logic [7:0] modem_control,
	input wire logic [7:0] divisor_fraction,
	input wire logic [7:0] enhanced_function
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	a_oe_needs_read: assert property ($rose(data_oe) |-> $past(ior_n, 2) == 1'b0 && $past(chan_sel_n, 2) == 1'b0)
		else $error("data drive without selected read");
	a_oe_release: assert property ($rose(ior_n) && data_oe |-> ##[1:4] !data_oe)
		else $error("data drive held after read end");
	a_idle_quiet: assert property (chan_sel_n [*6] |-> !data_oe && !tx_load_pulse && !rx_read_pulse)
		else $error("activity while channel deselected");
	a_tx_normal_bank: assert property (tx_load_pulse |-> !line_control[7] ##1 !tx_load_pulse)
		else $error("transmit load outside normal bank");
	a_rx_read_data: assert property (rx_read_pulse |-> data_oe && !line_control[7] && data_out == $past(rx_holding))
		else $error("receive read data wrong");
	a_fifo_reset_pulse: assert property (rx_fifo_reset || tx_fifo_reset |-> fifo_control[2:1] == 2'b00 ##1 !(rx_fifo_reset || tx_fifo_reset))
		else $error("fifo reset not a clean pulse");
	a_line_status_read: assert property (line_status_read_pulse |-> !line_control[7] && data_out == $past(line_status))
		else $error("line status read wrong");
	a_modem_status_read: assert property (modem_status_read_pulse |-> data_out == {$past(modem_state), $past(modem_delta)})
		else $error("modem status read wrong");
	// Allows the clear to land one cycle after the unlock bit drops
	a_locked_fields_zero: assert property (!enhanced_function[4] ##1 !enhanced_function[4] |-> interrupt_enable[7:4] == 4'h0
		&& fifo_control[5:4] == 2'h0 && modem_control[7:5] == 3'h0 && divisor_fraction == 8'h00)
		else $error("locked extended field not zero");
endmodule : ucrm_regs_asserts
bind ucrm_regs ucrm_regs_asserts u_chk (.sys_clk, .resetn, .chan_sel_n, .ior_n, .data_out, .data_oe, .rx_holding,
	.line_status, .modem_delta, .modem_state, .rx_read_pulse, .tx_load_pulse, .line_status_read_pulse,
	.modem_status_read_pulse, .rx_fifo_reset, .tx_fifo_reset, .interrupt_enable, .fifo_control, .line_control,
	.modem_control, .divisor_fraction, .enhanced_function);
`default_nettype wire

// *** ucrm_host.sv ***
// Purpose: Host processor model on the asynchronous strobe bus
// Assumes: Pins change on the falling clock edge
// Notes: Released lines show inverted values, never the last one
`timescale 1ns/100ps
`default_nettype none
module ucrm_host (
	input wire logic sys_clk,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	output logic chan_sel_n,
	output logic ior_n,
	output logic iow_n,
	output logic [2:0] addr,
	output logic [7:0] data_in
);
	initial begin
		chan_sel_n = 1'b1;
		ior_n = 1'b1;
		iow_n = 1'b1;
		addr = 3'h0;
		data_in = 8'h00;
	end
	// Hold h adds slow strobes; address held past strobe end
	task automatic wr(input logic sel_n, input logic [2:0] a, input logic [7:0] d, input int h);
		@(negedge sys_clk);
		chan_sel_n = sel_n;
		addr = a;
		data_in = d;
		iow_n = 1'b0;
		repeat (4 + h) @(negedge sys_clk);
		iow_n = 1'b1;
		repeat (2) @(negedge sys_clk);
		chan_sel_n = 1'b1;
		addr = ~a;
		data_in = ~d;
		repeat (4) @(negedge sys_clk);
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
		int n;
		@(negedge sys_clk);
		chan_sel_n = 1'b0;
		addr = a;
		ior_n = 1'b0;
		// Polled on the falling edge so the answer has settled
		for (n = 0; n < 8 && data_oe !== 1'b1; n++) @(negedge sys_clk);
		ok = data_oe;
		d = data_out;
		repeat (3) @(negedge sys_clk);
		ior_n = 1'b1;
		chan_sel_n = 1'b1;
		addr = ~a;
		repeat (5) @(negedge sys_clk);
	endtask : rd
endmodule : ucrm_host
`default_nettype wire

// *** uart_channel_register_map_tb.sv ***
// Purpose: Random register traffic against a bench model
// Assumes: Status inputs stay still during each access
// Notes: Banks are biased toward the enhanced key value
`timescale 1ns/100ps
`default_nettype none
module uart_channel_register_map_tb;
	import ucrm_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic chan_sel_n, ior_n, iow_n, data_oe, ok;
	logic [2:0] addr;
	logic [7:0] data_in, data_out, q, d;
	logic [7:0] rx_holding = 8'h00, line_status = 8'h00;
	logic [3:0] int_source = 4'h0, modem_delta = 4'h0, modem_state = 4'h0;
	logic pause_int_flag = 1'b0, handshake_int_flag = 1'b0;
	logic rx_read_pulse, tx_load_pulse, line_status_read_pulse, modem_status_read_pulse, rx_fifo_reset, tx_fifo_reset;
	logic [7:0] tx_holding, interrupt_enable, fifo_control, line_control, modem_control, scratch_pad;
	logic [7:0] divisor_low, divisor_high, divisor_fraction, enhanced_function;
	logic [7:0] resume_char_1, resume_char_2, pause_char_1, pause_char_2;
	logic [7:0] m_line = 8'h00, m_enh = 8'h00, m_ie = 8'h00, m_fifo = 8'h00, m_modem = 8'h00, m_scr = 8'h00;
	logic [7:0] m_dl = 8'h00, m_dh = 8'h00, m_frac = 8'h00, tx = 8'h00;
	logic [7:0] xc [4] = '{default: 8'h00};
	logic [31:0] seed = 77, r;
	int pc [6] = '{default: 0}, mc [6] = '{default: 0};
	int miscompares = 0, n_compared = 0, cyc = 0, i, k;
	always #5 sys_clk = ~sys_clk;
	ucrm_host host (.sys_clk, .data_out, .data_oe, .chan_sel_n, .ior_n, .iow_n, .addr, .data_in);
	ucrm_regs dut (.sys_clk, .resetn, .chan_sel_n, .addr, .ior_n, .iow_n, .data_in, .data_out, .data_oe, .rx_holding,
		.int_source, .pause_int_flag, .handshake_int_flag, .line_status, .modem_delta, .modem_state, .rx_read_pulse,
		.tx_load_pulse, .tx_holding, .line_status_read_pulse, .modem_status_read_pulse, .rx_fifo_reset, .tx_fifo_reset,
		.interrupt_enable, .fifo_control, .line_control, .modem_control, .scratch_pad, .divisor_low, .divisor_high,
		.divisor_fraction, .enhanced_function, .resume_char_1, .resume_char_2, .pause_char_1, .pause_char_2);
	// Pulses counted on the falling edge, away from the rising launch edge, to avoid a race
	always @(negedge sys_clk) begin
		pc[0] += rx_read_pulse;
		pc[1] += tx_load_pulse;
		pc[2] += line_status_read_pulse;
		pc[3] += modem_status_read_pulse;
		pc[4] += rx_fifo_reset;
		pc[5] += tx_fifo_reset;
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test;
		end
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	function automatic int bank();
		return (m_line == ENHANCED_KEY) ? 2 : int'(m_line[7]);
	endfunction : bank
	function automatic logic [7:0] mread(input logic [2:0] a);
		logic en;
		int b;
		en = m_enh[4];
		b = bank();
		case (a)
			0: return b == 0 ? rx_holding : m_dl;
			1: return b == 0 ? m_ie : m_dh;
			2: return b == 2 ? m_enh : b == 1 ? (en ? m_frac : 8'h00)
				: {m_fifo[0], m_fifo[0], en ? {handshake_int_flag, pause_int_flag} : 2'b00, int_source};
			3: return m_line;
			4: return b == 2 ? xc[0] : m_modem;
			5: return b == 2 ? xc[1] : b == 0 ? line_status : 8'h00;
			6: return b == 2 ? xc[2] : b == 0 ? {modem_state, modem_delta} : 8'h00;
			default: return b == 2 ? xc[3] : m_scr;
		endcase
	endfunction : mread
	task automatic mwrite(input logic [2:0] a, input logic [7:0] v);
		logic en;
		int b;
		en = m_enh[4];
		b = bank();
		case (a)
			0: if (b == 0) begin
				tx = v;
				mc[1]++;
			end else m_dl = v;
			1: if (b == 0) m_ie = en ? v : v & 8'h0F; else m_dh = v;
			2: if (b == 0) begin
				m_fifo = (en ? v : v & 8'hCF) & 8'hF9;
				mc[4] += v[1];
				mc[5] += v[2];
			end else if (b == 1) begin
				if (en) m_frac = v & 8'h3F;
			end else begin
				m_enh = v;
				if (!v[4]) begin
					m_ie &= 8'h0F;
					m_fifo &= 8'hCF;
					m_modem &= 8'h1F;
					m_frac = 8'h00;
				end
			end
			3: m_line = v;
			4: if (b == 2) xc[0] = v; else m_modem = en ? v : v & 8'h1F;
			7: if (b == 2) xc[3] = v; else m_scr = v;
			default: if (b == 2) xc[a - 4] = v;
		endcase
	endtask : mwrite
	task automatic check(input string nm, input logic [111:0] seen, input logic [111:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test();
		if (miscompares == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	initial begin
		repeat (4) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (3) @(negedge sys_clk);
		for (i = 0; i < 500; i++) begin
			r = rnd();
			{rx_holding, line_status, int_source, modem_delta, modem_state, pause_int_flag, handshake_int_flag} = r[29:0];
			r = rnd();
			d = (r[2:0] == 3'h3 && r[19:18] == 2'b00) ? ENHANCED_KEY : r[15:8];
			case (r[17:16])
				2'd2: begin
					host.rd(r[2:0], q, ok);
					check("drive", ok, 1'b1);
					check("read", q, mread(r[2:0]));
					if (bank() == 0 && r[2:0] == 3'h0) mc[0]++;
					if (bank() == 0 && r[2:0] == 3'h5) mc[2]++;
					if (bank() == 0 && r[2:0] == 3'h6) mc[3]++;
				end
				2'd3: host.wr(1'b1, r[2:0], d, 0);
				default: begin
					host.wr(1'b0, r[2:0], d, int'(r[21:20]));
					mwrite(r[2:0], d);
				end
			endcase
			check("regs", {interrupt_enable, fifo_control, line_control, modem_control, scratch_pad, divisor_low,
				divisor_high, divisor_fraction, enhanced_function, resume_char_1, resume_char_2, pause_char_1,
				pause_char_2, tx_holding}, {m_ie, m_fifo, m_line, m_modem, m_scr, m_dl, m_dh, m_frac, m_enh,
				xc[0], xc[1], xc[2], xc[3], tx});
			for (k = 0; k < 6; k++) check("pulses", pc[k], mc[k]);
		end
		stop_test;
	end
endmodule : uart_channel_register_map_tb
`default_nettype wire
